// ==== rtl/out_scale_defines.svh ====
// Constants for the output scaling and source selection block.
// Contract
// - Drive type codes: 0 unused, 10 voltage, 20 current, 40 pwm, 500 frequency, 1020 digital.
// - Default ranges: -10000..10000 mV, 0..24 mA, 0..1000 x0.1%, 50..30000 Hz.
// - Reset leaves the drive type at voltage.
// - Type change with auto update set reloads scaling and decimal digits; flag set at reset.
// - All types except unused and digital on/off follow y = m*x + a; unused gives zero.
// - Slope and offset come from the two input and two output scale points.
// - The result is clamped to the two output scale values.
// - Source codes 0 to 9: ignored, message, relay, table, math, logic, cmd, feedback, supply, temp.
// - Reset selects the received message of this output.
// - A number field picks the sub-signal; with the source ignored it is unused.
// - Message numbers: 1-2 output command or write state, 3 relay entry, 4-9 spare values.
// - Message numbers 1-2 use the write state for digital type, else the command.
// - Relay source number 1 takes write state entry three.
// - Table source numbers 1 to 10 pick that table's output.
// - Math source numbers 1 to 4 pick that math output.
// - Logic source numbers 1 to 3 pick the table chosen by that logic block.
// - Commanded and feedback sources, numbers 1-2, pick value or digital state; feedback always takes the value.
// - Supply and temperature sources ignore the number field.
`ifndef OUT_SCALE_DEFINES_SVH
`define OUT_SCALE_DEFINES_SVH
`define TYPE_UNUSED 11'h000
`define TYPE_VOLT 11'h00a
`define TYPE_CURR 11'h014
`define TYPE_PWM 11'h028
`define TYPE_FREQ 11'h1f4
`define TYPE_DIG 11'h3fc
`define SRC_NONE 4'h0
`define SRC_MSG 4'h1
`define SRC_RELAY 4'h2
`define SRC_TABLE 4'h3
`define SRC_MATH 4'h4
`define SRC_LOGIC 4'h5
`define SRC_CMD 4'h6
`define SRC_FDBK 4'h7
`define SRC_SUPPLY 4'h8
`define SRC_TEMP 4'h9
`define OFF_CTRL 8'h00
`define OFF_SEL 8'h04
`define OFF_IN_LO 8'h08
`define OFF_IN_HI 8'h0c
`define OFF_OUT_LO 8'h10
`define OFF_OUT_HI 8'h14
`define OFF_SEL_VAL 8'h18
`define OFF_FIELD 8'h1c
`define CTRL_TYPE_LSB 0
`define CTRL_TYPE_MSB 10
`define CTRL_AUTO_BIT 16
`define CTRL_DEC_LSB 24
`define CTRL_DEC_MSB 27
`define SEL_SRC_LSB 0
`define SEL_SRC_MSB 3
`define SEL_NUM_LSB 8
`define SEL_NUM_MSB 11
`define VOLT_LO 32'hffffd8f0
`define VOLT_HI 32'h00002710
`define CURR_HI 32'h00000018
`define PWM_HI 32'h000003e8
`define FREQ_LO 32'h00000032
`define FREQ_HI 32'h00007530
`define DIG_ON 32'h00000001
`define ZERO32 32'h00000000
`define IN_LO_DFLT 32'h00000000
`define IN_HI_DFLT 32'h00002710
`define DEC_DFLT 4'h0
`define AUTO_DFLT 1'b1
`define OWN_NUM 4'h1
`endif

// ==== rtl/out_scale_pkg.sv ====
// Types shared by the output scaling files.
package out_scale_pkg;
  // Every candidate control value that a source and number may pick.
  typedef struct packed {
    logic [1:0][31:0] received_output_command;
    logic [2:0] write_state;
    logic [5:0][31:0] spare_received_value;
    logic [9:0][31:0] table_out;
    logic [3:0][31:0] math_out;
    logic [2:0][31:0] logic_out;
    logic [1:0][31:0] commanded_value;
    logic [1:0] onoff_logic_state;
    logic [1:0][31:0] output_feedback_value;
    logic [31:0] supply_value;
    logic [31:0] temperature_value;
  } src_bus_t;
  // The four scale points of one output.
  typedef struct packed {
    logic [31:0] in_lo;
    logic [31:0] in_hi;
    logic [31:0] out_lo;
    logic [31:0] out_hi;
  } scale_t;
endpackage

// ==== rtl/linear_scaler.sv ====
// Combinational linear scaling with clamping at the output scale points.
`timescale 1ns/10ps
module linear_scaler (
  input wire logic [31:0] x,
  input wire out_scale_pkg::scale_t sc,
  output logic [31:0] y
);
  logic signed [63:0] dx;
  logic signed [63:0] span;
  logic signed [63:0] dy;
  logic signed [63:0] prod;
  logic signed [63:0] quot;
  logic below;
  logic above;
  logic [31:0] lin;

  // Differences are taken at double width so that no span overflows.
  assign dx = $signed({{32{x[31]}}, x}) - $signed({{32{sc.in_lo[31]}}, sc.in_lo});
  assign span = $signed({{32{sc.in_hi[31]}}, sc.in_hi}) - $signed({{32{sc.in_lo[31]}}, sc.in_lo});
  assign dy = $signed({{32{sc.out_hi[31]}}, sc.out_hi}) - $signed({{32{sc.out_lo[31]}}, sc.out_lo});
  // Offset from the low point times the output span, then one division by the input span: y = m*x + a.
  assign prod = dx * dy;
  assign quot = (span > 64'sh0) ? prod / span : 64'sh0;
  assign lin = sc.out_lo + quot[31:0];

  // Outside the input span the output holds at the matching output point.
  assign below = $signed(x) <= $signed(sc.in_lo);
  assign above = $signed(x) >= $signed(sc.in_hi);
  // A reversed output pair gives a falling response with no extra logic.
  assign y = below ? sc.out_lo : (above ? sc.out_hi : lin);
endmodule

// ==== rtl/output_scaling_source_select.sv ====
// Output channel: APB registers, control source selection and scaled field value.
`timescale 1ns/10ps
`include "out_scale_defines.svh"
module output_scaling_source_select (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire out_scale_pkg::src_bus_t src_in,
  output logic [10:0] output_drive_type,
  output logic [3:0] decimal_digits,
  output logic drive_active,
  output logic [31:0] field_value
);
  // ====================================================
  // Functions
  // ====================================================
  // True when a one-based number lies within 1..max.
  function automatic logic num_ok(input logic [3:0] n, input logic [3:0] max);
    num_ok = (n != 4'h0) && (n <= max);
  endfunction

  // Default output span for each drive type; unknown codes get an empty span.
  function automatic logic [63:0] type_range(input logic [10:0] t);
    unique case (t)
      `TYPE_VOLT: type_range = {`VOLT_LO, `VOLT_HI};
      `TYPE_CURR: type_range = {`ZERO32, `CURR_HI};
      `TYPE_PWM: type_range = {`ZERO32, `PWM_HI};
      `TYPE_FREQ: type_range = {`FREQ_LO, `FREQ_HI};
      `TYPE_DIG: type_range = {`ZERO32, `DIG_ON};
      default: type_range = {`ZERO32, `ZERO32};
    endcase
  endfunction

  // Widens a single state bit to a control value.
  function automatic logic [31:0] bit32(input logic b);
    bit32 = b ? `DIG_ON : `ZERO32;
  endfunction

  // Picks the control value that a source and number address.
  function automatic logic [31:0] pick(input logic [3:0] s, input logic [3:0] n,
                                       input out_scale_pkg::src_bus_t b, input logic dig);
    logic [3:0] i;
    i = n - 4'h1;
    pick = `ZERO32;
    unique case (s)
      `SRC_MSG: begin
        if (num_ok(n, 4'h2)) begin
          pick = dig ? bit32(b.write_state[i[1:0]]) : b.received_output_command[i[0]];
        end else if (n == 4'h3) begin
          pick = bit32(b.write_state[2]);
        end else if (n >= 4'h4 && n <= 4'h9) begin
          pick = b.spare_received_value[3'(n - 4'h4)];
        end
      end
      `SRC_RELAY: begin
        if (n == 4'h1) begin
          pick = bit32(b.write_state[2]);
        end
      end
      `SRC_TABLE: begin
        if (num_ok(n, 4'ha)) begin
          pick = b.table_out[i];
        end
      end
      `SRC_MATH: begin
        if (num_ok(n, 4'h4)) begin
          pick = b.math_out[i[1:0]];
        end
      end
      `SRC_LOGIC: begin
        if (num_ok(n, 4'h3)) begin
          pick = b.logic_out[i[1:0]];
        end
      end
      `SRC_CMD: begin
        if (num_ok(n, 4'h2)) begin
          pick = dig ? bit32(b.onoff_logic_state[i[0]]) : b.commanded_value[i[0]];
        end
      end
      `SRC_FDBK: begin
        if (num_ok(n, 4'h2)) begin
          pick = b.output_feedback_value[i[0]];
        end
      end
      `SRC_SUPPLY: pick = b.supply_value;
      `SRC_TEMP: pick = b.temperature_value;
      default: pick = `ZERO32;
    endcase
  endfunction

  // ====================================================
  // State
  // ====================================================
  logic [10:0] type_q;
  logic [10:0] type_d;
  logic auto_q;
  logic auto_d;
  logic [3:0] dec_q;
  logic [3:0] dec_d;
  logic [3:0] src_q;
  logic [3:0] src_d;
  logic [3:0] num_q;
  logic [3:0] num_d;
  out_scale_pkg::scale_t scale_q;
  out_scale_pkg::scale_t scale_d;
  logic [31:0] field_q;
  logic [31:0] field_d;
  logic [31:0] prdata_q;
  logic [31:0] prdata_d;
  logic pready_q;
  logic slverr_q;
  logic slverr_d;
  logic drive_q;

  // ====================================================
  // APB decode
  // ====================================================
  // The slave answers in the first access cycle; setup decides data and error.
  logic setup_w;
  logic wr_w;
  logic hit_ctrl;
  logic hit_sel;
  logic hit_in_lo;
  logic hit_in_hi;
  logic hit_out_lo;
  logic hit_out_hi;
  logic hit_sel_val;
  logic hit_field;
  logic mapped_w;
  logic ro_hit_w;
  assign setup_w = psel && !penable;
  assign wr_w = psel && penable && pready_q && pwrite && !slverr_q;
  assign hit_ctrl = paddr == `OFF_CTRL;
  assign hit_sel = paddr == `OFF_SEL;
  assign hit_in_lo = paddr == `OFF_IN_LO;
  assign hit_in_hi = paddr == `OFF_IN_HI;
  assign hit_out_lo = paddr == `OFF_OUT_LO;
  assign hit_out_hi = paddr == `OFF_OUT_HI;
  assign hit_sel_val = paddr == `OFF_SEL_VAL;
  assign hit_field = paddr == `OFF_FIELD;
  assign ro_hit_w = hit_sel_val || hit_field;
  assign mapped_w = hit_ctrl || hit_sel || hit_in_lo || hit_in_hi || hit_out_lo || hit_out_hi || ro_hit_w;
  // Writes to the read-only words are refused like unmapped ones; the flag stands only in the access cycle.
  assign slverr_d = setup_w && (!mapped_w || (pwrite && ro_hit_w));

  // ====================================================
  // Control source and scaling
  // ====================================================
  logic is_dig_w;
  logic [31:0] sel_w;
  logic [31:0] scaled_w;
  assign is_dig_w = type_q == `TYPE_DIG;
  assign sel_w = pick(src_q, num_q, src_in, is_dig_w);

  linear_scaler u_scaler (
    .x(sel_w),
    .sc(scale_q),
    .y(scaled_w)
  );

  // Digital type switches on any non-zero control; unused or ignored gives zero.
  always_comb begin
    if (type_q == `TYPE_DIG) begin
      field_d = (sel_w != `ZERO32) ? `DIG_ON : `ZERO32;
    end else if (type_q == `TYPE_UNUSED || src_q == `SRC_NONE) begin
      field_d = `ZERO32;
    end else begin
      field_d = scaled_w;
    end
  end

  // ====================================================
  // Register writes
  // ====================================================
  // A new type reloads its defaults only while automatic update is on.
  logic ctrl_wr_w;
  logic reload_w;
  logic [63:0] new_rng_w;
  assign ctrl_wr_w = wr_w && hit_ctrl;
  assign type_d = ctrl_wr_w ? pwdata[`CTRL_TYPE_MSB:`CTRL_TYPE_LSB] : type_q;
  assign auto_d = ctrl_wr_w ? pwdata[`CTRL_AUTO_BIT] : auto_q;
  assign reload_w = ctrl_wr_w && auto_q && (type_d != type_q);
  assign new_rng_w = type_range(type_d);
  assign src_d = (wr_w && hit_sel) ? pwdata[`SEL_SRC_MSB:`SEL_SRC_LSB] : src_q;
  assign num_d = (wr_w && hit_sel) ? pwdata[`SEL_NUM_MSB:`SEL_NUM_LSB] : num_q;

  // Reload wins over a direct decimal write in the same word.
  always_comb begin
    dec_d = dec_q;
    if (reload_w) begin
      dec_d = `DEC_DFLT;
    end else if (ctrl_wr_w) begin
      dec_d = pwdata[`CTRL_DEC_MSB:`CTRL_DEC_LSB];
    end
  end

  // Scale points change by direct write or by a type reload.
  always_comb begin
    scale_d = scale_q;
    if (reload_w) begin
      scale_d.in_lo = `IN_LO_DFLT;
      scale_d.in_hi = `IN_HI_DFLT;
      scale_d.out_lo = new_rng_w[63:32];
      scale_d.out_hi = new_rng_w[31:0];
    end
    if (wr_w && hit_in_lo) begin
      scale_d.in_lo = pwdata;
    end
    if (wr_w && hit_in_hi) begin
      scale_d.in_hi = pwdata;
    end
    if (wr_w && hit_out_lo) begin
      scale_d.out_lo = pwdata;
    end
    if (wr_w && hit_out_hi) begin
      scale_d.out_hi = pwdata;
    end
  end

  // Read data is fixed at setup so prdata leaves a flip-flop.
  always_comb begin
    prdata_d = prdata_q;
    if (setup_w) begin
      prdata_d = `ZERO32;
      if (hit_ctrl) begin
        prdata_d[`CTRL_TYPE_MSB:`CTRL_TYPE_LSB] = type_q;
        prdata_d[`CTRL_AUTO_BIT] = auto_q;
        prdata_d[`CTRL_DEC_MSB:`CTRL_DEC_LSB] = dec_q;
      end
      if (hit_sel) begin
        prdata_d[`SEL_SRC_MSB:`SEL_SRC_LSB] = src_q;
        prdata_d[`SEL_NUM_MSB:`SEL_NUM_LSB] = num_q;
      end
      if (hit_in_lo) prdata_d = scale_q.in_lo;
      if (hit_in_hi) prdata_d = scale_q.in_hi;
      if (hit_out_lo) prdata_d = scale_q.out_lo;
      if (hit_out_hi) prdata_d = scale_q.out_hi;
      if (hit_sel_val) prdata_d = sel_w;
      if (hit_field) prdata_d = field_q;
    end
  end

  // ====================================================
  // Flip-flops
  // ====================================================
  // Configuration registers and their reset values.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      type_q <= `TYPE_VOLT;
      auto_q <= `AUTO_DFLT;
      drive_q <= `TYPE_VOLT != `TYPE_UNUSED;
      dec_q <= `DEC_DFLT;
      src_q <= `SRC_MSG;
      num_q <= `OWN_NUM;
      scale_q <= {`IN_LO_DFLT, `IN_HI_DFLT, `VOLT_LO, `VOLT_HI};
    end else begin
      type_q <= type_d;
      auto_q <= auto_d;
      drive_q <= type_d != `TYPE_UNUSED;
      dec_q <= dec_d;
      src_q <= src_d;
      num_q <= num_d;
      scale_q <= scale_d;
    end
  end

  // Result register; one clock behind any input or setting change.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      field_q <= `ZERO32;
    end else begin
      field_q <= field_d;
    end
  end

  // Bus answer registers.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= `ZERO32;
      pready_q <= 1'b0;
      slverr_q <= 1'b0;
    end else begin
      prdata_q <= prdata_d;
      pready_q <= setup_w;
      slverr_q <= slverr_d;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = slverr_q;
  assign output_drive_type = type_q;
  assign decimal_digits = dec_q;
  assign drive_active = drive_q;
  assign field_value = field_q;

  // ====================================================
  // Assertions
  // ====================================================
  property p_reload;
    @(posedge pclk) disable iff (!presetn)
    reload_w |=> (scale_q.out_lo == $past(new_rng_w[63:32])) && (scale_q.out_hi == $past(new_rng_w[31:0]));
  endproperty
  a_reload: assert property (p_reload) else $error("type change did not reload scaling");

  property p_keep;
    @(posedge pclk) disable iff (!presetn)
    (ctrl_wr_w && !auto_q && !(wr_w && !hit_ctrl)) |=>
      $stable(scale_q) && (dec_q == $past(pwdata[`CTRL_DEC_MSB:`CTRL_DEC_LSB]));
  endproperty
  a_keep: assert property (p_keep) else $error("settings changed with auto update off");

  property p_voltage_span;
    @(posedge pclk) disable iff (!presetn)
    (reload_w && type_d == `TYPE_VOLT) |=> scale_q.out_lo == `VOLT_LO ##0 scale_q.out_hi == `VOLT_HI;
  endproperty
  a_voltage_span: assert property (p_voltage_span) else $error("voltage span wrong");

  property p_clamp;
    @(posedge pclk) disable iff (!presetn)
    ($signed(scale_q.in_lo) < $signed(scale_q.in_hi)) |->
      (($signed(scaled_w) >= $signed(scale_q.out_lo)) || ($signed(scaled_w) >= $signed(scale_q.out_hi))) &&
      (($signed(scaled_w) <= $signed(scale_q.out_lo)) || ($signed(scaled_w) <= $signed(scale_q.out_hi)));
  endproperty
  a_clamp: assert property (p_clamp) else $error("scaled value outside output points");

  property p_hold_low;
    @(posedge pclk) disable iff (!presetn)
    ($signed(sel_w) <= $signed(scale_q.in_lo)) |-> scaled_w == scale_q.out_lo;
  endproperty
  a_hold_low: assert property (p_hold_low) else $error("output not held at low point");

  property p_register;
    @(posedge pclk) disable iff (!presetn)
    (!is_dig_w && type_q != `TYPE_UNUSED && src_q != `SRC_NONE) |=> field_q == $past(scaled_w);
  endproperty
  a_register: assert property (p_register) else $error("field value not registered");

  property p_digital;
    @(posedge pclk) disable iff (!presetn)
    is_dig_w |=> field_q == (($past(sel_w) != `ZERO32) ? `DIG_ON : `ZERO32);
  endproperty
  a_digital: assert property (p_digital) else $error("digital output wrong");

  property p_msg_digital;
    @(posedge pclk) disable iff (!presetn)
    (src_q == `SRC_MSG && num_q == 4'h1 && is_dig_w) |-> sel_w == bit32(src_in.write_state[0]);
  endproperty
  a_msg_digital: assert property (p_msg_digital) else $error("message digital entry wrong");

  property p_supply;
    @(posedge pclk) disable iff (!presetn)
    src_q == `SRC_SUPPLY |-> sel_w == src_in.supply_value;
  endproperty
  a_supply: assert property (p_supply) else $error("supply source wrong");

  property p_ready;
    @(posedge pclk) disable iff (!presetn)
    setup_w |=> pready ##1 !pready;
  endproperty
  a_ready: assert property (p_ready) else $error("apb answer timing wrong");
endmodule

// ==== testbench/src_model.sv ====
// Behavioural fieldbus master that delivers every candidate control value.
`timescale 1ns/10ps
module src_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic msg_valid,
  input wire logic [31:0] msg_base,
  output out_scale_pkg::src_bus_t src_in
);
  // =========================================
  // Message contents
  // Entry k carries base + 3k, so a wrong pick reads as a wrong value, never a lucky match.
  function automatic out_scale_pkg::src_bus_t fill(input logic [31:0] b);
    out_scale_pkg::src_bus_t s;
    logic [30:0][31:0] v;
    for (int k = 0; k < 31; k++) v[k] = b + 32'(k) * 32'h3;
    s.received_output_command = v[1:0];
    s.spare_received_value = v[7:2];
    s.table_out = v[17:8];
    s.math_out = v[21:18];
    s.logic_out = v[24:22];
    s.commanded_value = v[26:25];
    s.output_feedback_value = v[28:27];
    s.supply_value = v[29];
    s.temperature_value = v[30];
    s.write_state = b[2:0];
    s.onoff_logic_state = b[4:3];
    return s;
  endfunction
  // A message replaces all values at once; between messages they hold.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_in <= '0;
    end else if (msg_valid) begin
      src_in <= fill(msg_base);
    end
  end
endmodule

// ==== testbench/output_scaling_source_select_tb.sv ====
// Self-checking bench for the output scaling and source selection block.
`timescale 1ns/10ps
module output_scaling_source_select_tb;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic msg_valid = 1'b0;
  logic [31:0] msg_base = 32'h0;
  out_scale_pkg::src_bus_t src_in;
  logic [10:0] output_drive_type;
  logic [3:0] decimal_digits;
  logic drive_active;
  logic [31:0] field_value;
  logic [33:0] exp_q[$];
  int n_fail = 0;
  int total_checks = 0;
  int seed = 32'h227da055;
  logic [10:0] ty [6] = '{11'h014, 11'h028, 11'h1f4, 11'h3fc, 11'h000, 11'h00a};
  logic [31:0] tlo [6] = '{32'h0, 32'h0, 32'h32, 32'h0, 32'h0, 32'hffffd8f0};
  logic [31:0] thi [6] = '{32'h18, 32'h3e8, 32'h7530, 32'h1, 32'h0, 32'h2710};
  logic [31:0] dsel [5] = '{32'h101, 32'h201, 32'h102, 32'h106, 32'h206};

  always #10 pclk = ~pclk;

  output_scaling_source_select u_output_scaling_source_select (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .src_in(src_in),
    .output_drive_type(output_drive_type),
    .decimal_digits(decimal_digits),
    .drive_active(drive_active),
    .field_value(field_value)
  );
  src_model u_src_model (
    .pclk(pclk),
    .presetn(presetn),
    .msg_valid(msg_valid),
    .msg_base(msg_base),
    .src_in(src_in)
  );

  // =========================================
  // Reporting
  task automatic fail(input string m);
    n_fail++;
    $display("Error at %0t: %s", $time, m);
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) fail($sformatf("port got %h want %h", g, e));
  endtask
  task automatic chk_bus(input logic [33:0] e);
    total_checks++;
    if (pslverr !== e[32] || (e[33] && !e[32] && prdata !== e[31:0])) fail("bus answer");
  endtask
  task automatic close_out;
    $display("Checks %0d, mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // =========================================
  // Bus master; each transfer notes {read, error, data} for the monitor.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic err);
    exp_q.push_back({~w, err, d});
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= w ? d : $random(seed);
    @(posedge pclk);
    penable <= 1'b1;
    // Only the watchdog ends a wait for the answer.
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 1'b0);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, e, 1'b0);
  endtask
  task automatic send(input logic [31:0] b);
    @(posedge pclk);
    msg_valid <= 1'b1;
    msg_base <= b;
    @(posedge pclk);
    msg_valid <= 1'b0;
  endtask
  // The answer is compared at the very edge where pready is sampled high.
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1) begin
      chk_bus(exp_q.pop_front());
    end
  end

  // =========================================
  // Expected pick, worked out independently of the model's packing helper.
  function automatic logic [31:0] ent(input logic [31:0] b, input int k);
    return b + 32'(k) * 32'h3;
  endfunction
  function automatic logic [31:0] exp_sel(input int s, input int n, input logic [31:0] b);
    logic [31:0] e;
    e = 32'h0;
    case (s)
      1: begin
        if (n == 1 || n == 2) e = ent(b, n - 1);
        else if (n == 3) e = {31'h0, b[2]};
        else if (n >= 4 && n <= 9) e = ent(b, n - 2);
      end
      2: if (n == 1) e = {31'h0, b[2]};
      3: if (n >= 1 && n <= 10) e = ent(b, n + 7);
      4: if (n >= 1 && n <= 4) e = ent(b, n + 17);
      5: if (n >= 1 && n <= 3) e = ent(b, n + 21);
      6: if (n == 1 || n == 2) e = ent(b, n + 24);
      7: if (n == 1 || n == 2) e = ent(b, n + 26);
      8: e = ent(b, 29);
      9: e = ent(b, 30);
      default: e = 32'h0;
    endcase
    return e;
  endfunction
  task automatic scale_case(input logic [31:0] lo, hi, olo, ohi, x, e);
    wr(8'h08, lo);
    wr(8'h0c, hi);
    wr(8'h10, olo);
    wr(8'h14, ohi);
    send(x);
    @(posedge pclk);
    #1 chk(field_value, e);
    rd(8'h1c, e);
  endtask

  // =========================================
  // Main sequence
  initial begin
    int x;
    logic [31:0] b;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    #1 chk(32'(output_drive_type), 32'h00a);
    chk(32'(drive_active), 32'h1);
    rd(8'h00, 32'h0001000a);
    rd(8'h04, 32'h00000101);
    rd(8'h10, 32'hffffd8f0);
    rd(8'h14, 32'h00002710);
    send(32'd7500);
    @(posedge pclk);
    #1 chk(field_value, 32'd5000);
    repeat (6) begin
      x = {$random(seed)} % 1001;
      scale_case(32'h0, 32'h3e8, 32'h0, 32'h4e20, 32'(x), 32'(20 * x));
    end
    scale_case(32'h0, 32'h3e8, 32'h0, 32'h4e20, 32'h5dc, 32'h4e20);
    scale_case(32'h0, 32'h3e8, 32'h0, 32'h4e20, -32'sd5, 32'h0);
    scale_case(32'h64, 32'h258, -32'sd1000, 32'hfa0, 32'h15e, 32'h5dc);
    // Input points stay strictly ordered; only the output points are swapped.
    scale_case(32'h0, 32'h3e8, 32'h4e20, 32'h0, 32'hfa, 32'h3a98);
    scale_case(32'h0, 32'h3e8, 32'h4e20, 32'h0, 32'h7d0, 32'h0);
    b = $random(seed);
    send(b);
    // Diagnostic sources are only read back here, never used to steer a drive.
    for (int s = 0; s < 10; s++) begin
      for (int n = 0; n < 12; n++) begin
        wr(8'h04, {20'h0, 4'(n), 4'h0, 4'(s)});
        rd(8'h18, exp_sel(s, n, b));
      end
    end
    wr(8'h04, 32'h00000101);
    for (int i = 0; i < 6; i++) begin
      wr(8'h00, {16'h0001, 5'h0, ty[i]});
      @(posedge pclk);
      #1 chk(32'(output_drive_type), 32'(ty[i]));
      chk(32'(drive_active), 32'(ty[i] != 11'h000));
      if (ty[i] != 11'h000) begin
        rd(8'h0c, 32'h2710);
        rd(8'h10, tlo[i]);
        rd(8'h14, thi[i]);
      end else begin
        chk(field_value, 32'h0);
      end
    end
    wr(8'h00, 32'h000103fc);
    send(32'h16);
    for (int i = 0; i < 5; i++) begin
      wr(8'h04, dsel[i]);
      @(posedge pclk);
      #1 chk(field_value, 32'(i != 0 && i != 3));
      rd(8'h18, 32'(i != 0 && i != 3));
    end
    // With automatic update off the bench owns every dependent setting.
    wr(8'h00, 32'h000003fc);
    wr(8'h0c, 32'h1388);
    wr(8'h00, 32'h03000014);
    @(posedge pclk);
    #1 chk(32'(decimal_digits), 32'h3);
    rd(8'h0c, 32'h1388);
    rd(8'h14, 32'h1);
    // A type change with auto update on restores the default decimals over the written ones.
    wr(8'h00, 32'h03010014);
    wr(8'h00, 32'h0501000a);
    @(posedge pclk);
    #1 chk(32'(decimal_digits), 32'h0);
    rd(8'h10, 32'hffffd8f0);
    apb(1'b0, 8'h20, 32'h0, 1'b1);
    apb(1'b1, 8'h1c, 32'h5, 1'b1);
    apb(1'b1, 8'h18, 32'h5, 1'b1);
    close_out();
  end

  initial begin
    // The sequence needs about 1,100 cycles; 20,000 leaves ample margin.
    #400000;
    fail("timeout");
    close_out();
  end
endmodule
